// [sps_regs.svh]
// register map, field positions, reset values and timing counts of the serial port
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// byte offsets on the register bus, one aligned word each
`define SPS_OFF_CTRL1      5'h00
`define SPS_OFF_CTRL2      5'h04
`define SPS_OFF_BAUD       5'h08
`define SPS_OFF_STATUS     5'h0c
`define SPS_OFF_DATA       5'h10

// control 1 fields
`define SPS_C1_ENABLE      6
`define SPS_C1_MASTER      4
`define SPS_C1_CPOL        3
`define SPS_C1_CPHA        2
`define SPS_C1_SEL_OUT     1
`define SPS_C1_LOW_FIRST   0
`define SPS_C1_MASK        8'h5f

// control 2 fields
`define SPS_C2_FAULT_EN    4
`define SPS_C2_SW_OE       3
`define SPS_C2_SW_SEL      0
`define SPS_C2_MASK        8'h19

// baud fields
`define SPS_BD_PRE_HI      6
`define SPS_BD_PRE_LO      4
`define SPS_BD_RATE_HI     2
`define SPS_BD_RATE_LO     0
`define SPS_BD_MASK        8'h77

// status fields
`define SPS_ST_RX_FULL     7
`define SPS_ST_TX_EMPTY    5
`define SPS_ST_FAULT       4

// reset values
`define SPS_RST_CTRL1      8'h04
`define SPS_RST_CTRL2      8'h00
`define SPS_RST_BAUD       8'h00

// last edge index and last sample index within a byte
`define SPS_EDGES_LAST     4'hf
`define SPS_BITS_LAST      3'h7

`endif

// [sps_pkg.sv]
// types shared by the serial port design files
`default_nettype none
package sps_pkg;

  // master sequencer states
  typedef enum logic [1:0] {
    SPS_IDLE = 2'b00,
    SPS_RUN  = 2'b01,
    SPS_GAP  = 2'b10
  } sps_state_t;

  // one pad as seen from the port: own means the port controls it
  typedef struct packed {
    logic own;
    logic o;
    logic oe;
  } sps_pin_t;

  // raw pin levels travelling through the synchroniser
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss;
  } sps_pads_t;

endpackage
`default_nettype wire

// [sps_sync.sv]
// two flip-flop synchroniser for pin levels
`default_nettype none
module sps_sync
  import sps_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule
`default_nettype wire

// [sps_top.sv]
// byte-wide synchronous serial port, master or slave, behind a wishbone slave
// Behaviour
// RQ1 - only a master starts transfers; a slave shifts on the master's clock only
// RQ2 - master shifts out and in at once, exchanging shift register contents
// RQ3 - the far master holds select low for the slave to take part
// RQ4 - written byte waits in transmit buffer until the next transfer starts
// RQ5 - a completed byte moves into a separate receive buffer for reading
// RQ6 - master drives clock, sends on master-out, samples master-in
// RQ7 - slave takes clock pin, sends on master-in, samples master-out
// RQ8 - prescale field divides the bus clock by field plus one
// RQ9 - rate field divides further by two up to 256
// RQ10 - with enable clear, the port releases all four pins
// RQ11 - single-wire master uses master-out pin, direction from output enable
// RQ12 - single-wire slave uses master-in pin, direction from output enable
// RQ13 - enabled slave always treats select pin as active-low input
// RQ14 - master with fault detect off releases select pin
// RQ15 - master with fault detect: fault input, or automatic select output
// RQ16 - any sleep level disables the port
// RQ17 - deep sleep levels leave every register at reset values
// RQ18 - light sleep freezes state and resumes from it
// RQ19 - five byte-wide registers: two controls, baud, status, data
// RQ20 - clearing enable aborts transfer, empties buffers, sets transmit-empty
// RQ21 - clock polarity picks the idle level of the serial clock
// RQ22 - clock phase puts the first edge mid-bit or at bit start
// RQ23 - bit order control picks msb first or lsb first
// RQ24 - automatic select is low during each byte, high between; here it stays low between bytes when the next byte is already waiting
// RQ25 - low fault input while master ends master mode and flags fault
//
// The implementer's own choices: the address map and the Wishbone register port.
`include "sps_regs.svh"
`default_nettype none
module sps_top
  import sps_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       deep_sleep,
  input  wire logic       light_sleep,
  input  wire logic       wb_cyc,
  input  wire logic       wb_stb,
  input  wire logic       wb_we,
  input  wire logic [4:0] wb_adr,
  input  wire logic [3:0] wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output var  logic [31:0] wb_dat_r,
  output var  logic       wb_ack,
  input  wire sps_pads_t  pad_in,
  output var  sps_pin_t   serial_clock_pin,
  output var  sps_pin_t   mosi_pin,
  output var  sps_pin_t   miso_pin,
  output var  sps_pin_t   select_pin
);

  logic       rst;
  logic       run;
  sps_pads_t  pads;
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] baud;
  logic [7:0] tx_buf;
  logic [7:0] rx_buf;
  logic       tx_empty;
  logic       rx_full;
  logic       fault;
  sps_state_t state;
  logic [3:0] edge_cnt;
  logic [10:0] div_cnt;
  logic [10:0] half_m1;
  logic       sck_int;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [2:0] bit_cnt;
  logic       sck_d;
  logic       ss_d;
  logic       req;
  logic       wr;
  logic       rd;
  logic       en;
  logic       master;
  logic       cpol;
  logic       cpha;
  logic       lsbf;
  logic       sw_sel;
  logic       tick;
  logic       ev;
  logic       lead;
  logic       sample;
  logic       shift;
  logic       in_bit;
  logic       out_bit;
  logic       done_ev;
  logic       m_start;
  logic       s_load;
  logic       load_ev;
  logic       fault_ev;
  logic [7:0] next_rx;

  // deep sleep powers the port down: treated as reset everywhere except the pin synchroniser
  assign rst = sys_rst | deep_sleep; // [RQ17]
  // light sleep stops the port clock, so nothing but the pin synchroniser, the pad release and the bus ack and read data moves while it lasts
  assign run = ~light_sleep; // [RQ18]

  sps_sync #(
    .W ($bits(sps_pads_t))
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (pad_in),
    .dout    (pads)
  );

  // field decode
  assign en     = ctrl1[`SPS_C1_ENABLE];
  assign master = ctrl1[`SPS_C1_MASTER];
  assign cpol   = ctrl1[`SPS_C1_CPOL];
  assign cpha   = ctrl1[`SPS_C1_CPHA];
  assign lsbf   = ctrl1[`SPS_C1_LOW_FIRST];
  assign sw_sel = ctrl2[`SPS_C2_SW_SEL];

  // bus strobes, taken once per request while ack is low
  assign req = wb_cyc & wb_stb & ~wb_ack & run;
  assign wr  = req & wb_we & wb_sel[0];
  assign rd  = req & ~wb_we;

  // register bus: every access is acked one cycle after it is seen
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack   <= 1'b0;
      wb_dat_r <= 32'h0;
    end else begin
      wb_ack   <= req;
      wb_dat_r <= 32'h0;
      if (rd) begin // [RQ19]
        case (wb_adr)
          `SPS_OFF_CTRL1:  wb_dat_r <= {24'h0, ctrl1};
          `SPS_OFF_CTRL2:  wb_dat_r <= {24'h0, ctrl2};
          `SPS_OFF_BAUD:   wb_dat_r <= {24'h0, baud};
          `SPS_OFF_STATUS: wb_dat_r <= {24'h0, rx_full, 1'b0, tx_empty, fault, 4'h0};
          `SPS_OFF_DATA:   wb_dat_r <= {24'h0, rx_buf};
          default:         wb_dat_r <= 32'h0;
        endcase
      end
    end
  end

  // configuration; a mode fault knocks the port out of master mode
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl1 <= `SPS_RST_CTRL1;
      ctrl2 <= `SPS_RST_CTRL2;
      baud  <= `SPS_RST_BAUD;
    end else if (run) begin
      if (wr && wb_adr == `SPS_OFF_CTRL1) begin
        ctrl1 <= wb_dat_w[7:0] & `SPS_C1_MASK;
      end
      if (wr && wb_adr == `SPS_OFF_CTRL2) begin
        ctrl2 <= wb_dat_w[7:0] & `SPS_C2_MASK;
      end
      if (wr && wb_adr == `SPS_OFF_BAUD) begin
        baud <= wb_dat_w[7:0] & `SPS_BD_MASK;
      end
      if (fault_ev) begin
        ctrl1[`SPS_C1_MASTER] <= 1'b0; // [RQ25]
      end
    end
  end

  // half bit period in bus clocks: (prescale + 1) * 2^rate
  assign half_m1 = ((11'(baud[`SPS_BD_PRE_HI:`SPS_BD_PRE_LO]) + 11'h1)
                    << baud[`SPS_BD_RATE_HI:`SPS_BD_RATE_LO]) - 11'h1; // [RQ8] [RQ9]
  assign tick    = (state != SPS_IDLE) && (div_cnt == half_m1);

  // fault input sampled only as master with detect on and select output off
  assign fault_ev = en & master & ctrl2[`SPS_C2_FAULT_EN] & ~ctrl1[`SPS_C1_SEL_OUT] & ~pads.ss; // [RQ15]
  assign m_start  = en & master & (state == SPS_IDLE) & ~tx_empty & ~fault_ev; // [RQ1] [RQ4]
  assign s_load   = en & ~master & ~pads.ss & (ss_d | done_ev); // [RQ13]
  assign load_ev  = m_start | s_load;

  // shift events from the internal clock as master, from the pin as slave
  assign ev   = master ? (tick && state == SPS_RUN)
                       : (en && ~pads.ss && pads.sck != sck_d); // [RQ3] [RQ7]
  assign lead = master ? (sck_int == cpol) : (sck_d == cpol); // [RQ21]
  // phase 0 samples on leading edges, phase 1 on trailing
  assign sample = ev & (lead ^ cpha); // [RQ22]
  assign shift  = ev & ~(lead ^ cpha) & (bit_cnt != 3'h0);
  assign done_ev = sample & (bit_cnt == `SPS_BITS_LAST);

  // data line choice per mode; single-wire shares one pin both ways
  always_comb begin
    if (master) begin
      in_bit = sw_sel ? pads.mosi : pads.miso; // [RQ6] [RQ11]
    end else begin
      in_bit = sw_sel ? pads.miso : pads.mosi; // [RQ7] [RQ12]
    end
  end
  assign out_bit = lsbf ? tx_sh[0] : tx_sh[7]; // [RQ23]
  assign next_rx = lsbf ? {in_bit, rx_sh[7:1]} : {rx_sh[6:0], in_bit}; // [RQ23]

  // buffers and flags; a hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_buf   <= 8'h0;
      rx_buf   <= 8'h0;
      tx_empty <= 1'b1;
      rx_full  <= 1'b0;
      fault    <= 1'b0;
    end else if (run) begin
      if (!en) begin
        tx_empty <= 1'b1; // [RQ20]
        rx_full  <= 1'b0;
      end else begin
        if (wr && wb_adr == `SPS_OFF_DATA) begin
          tx_buf   <= wb_dat_w[7:0];
          tx_empty <= 1'b0;
        end
        if (load_ev) begin
          tx_empty <= 1'b1; // [RQ4]
        end
        if (rd && wb_adr == `SPS_OFF_DATA) begin
          rx_full <= 1'b0;
        end
        if (done_ev) begin
          rx_buf  <= next_rx; // [RQ5]
          rx_full <= 1'b1;
        end
      end
      // fault clears on a write to control 1 unless it is raised again
      if (wr && wb_adr == `SPS_OFF_CTRL1) begin
        fault <= 1'b0;
      end
      if (fault_ev) begin
        fault <= 1'b1; // [RQ25]
      end
    end
  end

  // master sequencer: 16 clock edges per byte, one idle half bit after
  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= SPS_IDLE;
      edge_cnt <= 4'h0;
      div_cnt  <= 11'h0;
      sck_int  <= 1'b0;
    end else if (run) begin
      div_cnt <= tick ? 11'h0 : div_cnt + 11'h1;
      if (!en || !master || fault_ev) begin
        state    <= SPS_IDLE; // [RQ20] [RQ25]
        edge_cnt <= 4'h0;
        div_cnt  <= 11'h0;
        sck_int  <= cpol;
      end else begin
        case (state)
          SPS_IDLE: begin
            div_cnt <= 11'h0;
            sck_int <= cpol; // [RQ21]
            if (m_start) begin
              state    <= SPS_RUN;
              edge_cnt <= 4'h0;
            end
          end
          SPS_RUN: begin
            if (tick) begin
              sck_int  <= ~sck_int; // [RQ2]
              edge_cnt <= edge_cnt + 4'h1;
              if (edge_cnt == `SPS_EDGES_LAST) begin
                state <= SPS_GAP;
              end
            end
          end
          SPS_GAP: begin
            if (tick) begin
              state <= SPS_IDLE;
            end
          end
          default: state <= SPS_IDLE;
        endcase
      end
    end
  end

  // shared shifter, driven by either clock source
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_sh   <= 8'h0;
      rx_sh   <= 8'h0;
      bit_cnt <= 3'h0;
      sck_d   <= 1'b0;
      ss_d    <= 1'b1;
    end else if (run) begin
      sck_d <= pads.sck;
      ss_d  <= pads.ss;
      if (!en || (!master && pads.ss) || fault_ev) begin
        bit_cnt <= 3'h0; // [RQ20] [RQ13]
        rx_sh   <= 8'h0;
      end else begin
        if (sample) begin
          rx_sh   <= next_rx; // [RQ2]
          bit_cnt <= bit_cnt + 3'h1;
        end
        if (shift) begin
          tx_sh <= lsbf ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
        end
        if (load_ev) begin
          tx_sh <= tx_buf; // [RQ4]
        end
      end
    end
  end

  // pad control, registered; sleep or disable releases every pad
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_clock_pin <= '0;
      mosi_pin         <= '0;
      miso_pin         <= '0;
      select_pin       <= '0;
    end else begin
      serial_clock_pin <= '0;
      mosi_pin         <= '0;
      miso_pin         <= '0;
      select_pin       <= '0;
      if (en && run) begin // [RQ10] [RQ16]
        if (master) begin
          serial_clock_pin <= '{own: 1'b1, o: sck_int, oe: 1'b1}; // [RQ6]
          mosi_pin <= '{own: 1'b1, o: out_bit, oe: ~sw_sel | ctrl2[`SPS_C2_SW_OE]}; // [RQ11]
          miso_pin <= '{own: ~sw_sel, o: 1'b0, oe: 1'b0}; // [RQ11]
          if (ctrl2[`SPS_C2_FAULT_EN]) begin // [RQ14]
            // select is low from transfer start until the gap ends
            select_pin <= '{own: 1'b1, o: (state == SPS_IDLE) && !m_start,
                            oe: ctrl1[`SPS_C1_SEL_OUT]}; // [RQ15] [RQ24]
          end
        end else begin
          serial_clock_pin <= '{own: 1'b1, o: 1'b0, oe: 1'b0}; // [RQ7]
          select_pin       <= '{own: 1'b1, o: 1'b0, oe: 1'b0}; // [RQ13]
          mosi_pin         <= '{own: ~sw_sel, o: 1'b0, oe: 1'b0}; // [RQ12]
          // drive only while selected, so several slaves can share the line
          miso_pin <= '{own: 1'b1, o: out_bit,
                        oe: ~pads.ss & (~sw_sel | ctrl2[`SPS_C2_SW_OE])}; // [RQ7] [RQ12]
        end
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // the sequencer drops to idle one edge after master mode goes away
  slave_no_start_a: assert property (!master && run |=> state == SPS_IDLE) // [RQ1]
    else $error("slave left the idle state");
  start_empties_a: assert property (m_start && run |=> tx_empty && state == SPS_RUN) // [RQ4]
    else $error("start did not take the buffer");
  done_fills_a: assert property (done_ev && en && run |=> rx_full && rx_buf == $past(next_rx)) // [RQ5]
    else $error("byte not moved to receive buffer");
  disable_release_a: assert property (!en |=> !serial_clock_pin.own && !mosi_pin.own
                                      && !miso_pin.own && !select_pin.own) // [RQ10]
    else $error("pads held while disabled");
  disable_flags_a: assert property (!en && run |=> tx_empty && !rx_full && state == SPS_IDLE) // [RQ20]
    else $error("disable did not clear buffers");
  sleep_release_a: assert property (light_sleep |=> !serial_clock_pin.own && !mosi_pin.own) // [RQ16]
    else $error("pads held in sleep");
  sleep_freeze_a: assert property (light_sleep |=> $stable(state) && $stable(tx_sh) && $stable(div_cnt)) // [RQ18]
    else $error("state moved in light sleep");
  fault_drop_a: assert property (fault_ev && run |=> fault && !master) // [RQ25]
    else $error("fault did not end master mode");
  div_bound_a: assert property (state == SPS_RUN && run |-> div_cnt <= half_m1) // [RQ8]
    else $error("divider passed its limit");
  master_clk_a: assert property (master && ev && en && run && !fault_ev |=> sck_int != $past(sck_int)) // [RQ9]
    else $error("master clock did not toggle");
  master_byte_c: cover property (m_start ##[1:300] done_ev);
  slave_byte_c: cover property (!master && done_ev);
  fault_seen_c: cover property (fault_ev);
  sleep_resume_c: cover property (state == SPS_RUN ##1 light_sleep [*3] ##1 !light_sleep);
endmodule
`default_nettype wire

// [sps_slave_model.sv]
// behavioural far-side serial slave used by the port bench
`default_nettype none
module sps_slave_model (
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  output var  logic       miso,
  output var  logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ns;
  int k;

  // bit i of the outgoing byte in the chosen order
  function automatic logic pick(input logic [7:0] b, input int i);
    return lsb ? b[i[2:0]] : b[3'd7-i[2:0]];
  endfunction

  initial begin
    miso = 1'b0;
    rx = 8'h00;
    k = 0;
  end

  // select arms a byte; on release the line flips, not held at the last bit
  always @(ss_n) begin
    k = 0;
    miso = ss_n ? ~miso : pick(tx, 0);
  end

  // only the master's clock moves bits, both ways at once
  always @(sck) begin
    if (!ss_n && k < 8) begin
      if ((sck != cpol) ^ cpha) begin
        rx[lsb ? k : 7-k] = mosi;
        k++;
      end else begin
        miso = pick(tx, k);
      end
    end
  end
endmodule
`default_nettype wire

// [sps_top_test.sv]
// self-checking bench for the serial port: registers, pins, master and slave bytes, sleep
`include "sps_regs.svh"
`default_nettype none
module sps_top_test
  import sps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, sys_rst, deep_sleep, light_sleep, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [4:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  sps_pads_t   pads;
  sps_pin_t    sck_p, mosi_p, miso_p, sel_p;
  logic        tb_sck, tb_mosi, tb_ss, m_miso, m_off, cpol, cpha, lsb, last_sck;
  logic [7:0]  m_tx, m_rx, d, m, po;
  logic [8:0]  exp_q[$];
  logic [8:0]  mon_e;
  int          err_total, checked, half, hcnt, h;

  // each pad level comes from whichever party enables its driver
  assign pads = {sck_p.oe ? sck_p.o : tb_sck, mosi_p.oe ? mosi_p.o : tb_mosi,
                 miso_p.oe ? miso_p.o : m_miso, sel_p.oe ? sel_p.o : tb_ss};
  assign po = {sck_p.own, sck_p.oe, mosi_p.own, mosi_p.oe, miso_p.own, miso_p.oe, sel_p.own, sel_p.oe};

  sps_top dut (.clk(clk), .sys_rst(sys_rst), .deep_sleep(deep_sleep), .light_sleep(light_sleep),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .pad_in(pads),
    .serial_clock_pin(sck_p), .mosi_pin(mosi_p), .miso_pin(miso_p), .select_pin(sel_p));

  sps_slave_model far (.sck(pads.sck), .ss_n(pads.ss | m_off), .mosi(pads.mosi), .cpol(cpol),
    .cpha(cpha), .lsb(lsb), .tx(m_tx), .miso(m_miso), .rx(m_rx));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one classic cycle; the expected read byte is noted before the request
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] dw, input logic [7:0] e);
    int n;
    n = 0;
    exp_q.push_back({~we, e});
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'h1;
    wb_dat_w <= {24'h0, dw};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED bus ack expected 1 seen 0");
      complete_run();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] dw);
    bus(1'b1, a, dw, 8'h00);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, e);
  endtask

  task automatic wait_sel(input logic lv, input int bound);
    int n;
    n = 0;
    while (sel_p.o !== lv && n < bound) begin
      @(posedge clk);
      n++;
    end
    if (sel_p.o !== lv) begin
      err_total++;
      $display("CHECK FAILED select level expected %b seen %b", lv, sel_p.o);
      complete_run();
    end
  endtask

  // read answers are matched against the oldest note
  always @(posedge clk) begin
    if (wb_ack === 1'b1) begin
      mon_e = exp_q.pop_front();
      if (mon_e[8]) chk("read data", wb_dat_r, {24'h0, mon_e[7:0]});
    end
  end

  // spacing of serial clock toggles, to measure the half period
  always @(posedge clk) begin
    hcnt++;
    if (sck_p.o !== last_sck) begin
      half = hcnt;
      hcnt = 0;
      last_sck = sck_p.o;
    end
  end

  initial begin
    logic [7:0] c1t[5] = '{8'h50, 8'h50, 8'h50, 8'h50, 8'h40};
    logic [7:0] c2t[5] = '{8'h10, 8'h00, 8'h09, 8'h01, 8'h01};
    logic [7:0] pt[5] = '{8'hfa, 8'hf8, 8'hf0, 8'he0, 8'h8a};
    logic [2:0] pre, rate;
    {sys_rst, deep_sleep, light_sleep, wb_cyc, wb_stb, wb_we} = 6'b100000;
    {wb_adr, wb_sel, wb_dat_w} = '0;
    {tb_sck, tb_mosi, tb_ss, m_off, cpol, cpha, lsb, last_sck} = 8'b00100000;
    m_tx = 8'h00;
    {err_total, checked, hcnt, half} = '0;
    void'($urandom(58));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // reset values, masks, read-only status, unmapped place
    rd(`SPS_OFF_CTRL1, 8'h04);
    rd(`SPS_OFF_STATUS, 8'h20);
    rd(5'h14, 8'h00);
    chk("pin use", 32'(po), 32'h0);
    wr(`SPS_OFF_CTRL2, 8'hff);
    rd(`SPS_OFF_CTRL2, 8'h19);
    wr(`SPS_OFF_BAUD, 8'hff);
    rd(`SPS_OFF_BAUD, 8'h77);
    wr(`SPS_OFF_STATUS, 8'h00);
    rd(`SPS_OFF_STATUS, 8'h20);
    $display("test registers done");
    // master bytes in every polarity, phase and order, last one at the slowest rate
    for (int i = 0; i < 9; i++) begin
      {cpol, cpha, lsb} = i[2:0];
      pre = (i == 8) ? 3'h7 : 3'(1 + $urandom % 7);
      rate = (i == 8) ? 3'h7 : 3'(1 + $urandom % 3);
      h = (int'(pre) + 1) << rate;
      m_tx = 8'($urandom);
      d = 8'($urandom);
      wr(`SPS_OFF_BAUD, {1'b0, pre, 1'b0, rate});
      wr(`SPS_OFF_CTRL2, 8'h10);
      wr(`SPS_OFF_CTRL1, {4'h5, cpol, cpha, 1'b1, lsb});
      // the idle level reaches the pad two edges after the control write
      @(posedge clk);
      chk("clock idle", 32'(sck_p.o), 32'(cpol));
      chk("pin use", 32'(po), 32'hfb);
      wr(`SPS_OFF_DATA, d);
      wait_sel(1'b0, 20);
      wait_sel(1'b1, 17 * h + 20);
      chk("half period", 32'(half), 32'(h));
      chk("far side byte", 32'(m_rx), 32'(d));
      rd(`SPS_OFF_STATUS, 8'ha0);
      rd(`SPS_OFF_DATA, m_tx);
      rd(`SPS_OFF_STATUS, 8'h20);
    end
    $display("test master transfers done");
    // pin routing with select released or as fault input, and for single-wire settings
    m_off = 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(`SPS_OFF_CTRL2, c2t[i]);
      wr(`SPS_OFF_CTRL1, c1t[i]);
      @(posedge clk);
      chk("pin use", 32'(po), 32'(pt[i]));
    end
    // a low fault input ends master operation
    wr(`SPS_OFF_CTRL2, 8'h10);
    wr(`SPS_OFF_CTRL1, 8'h50);
    tb_ss <= 1'b0;
    repeat (4) @(posedge clk);
    rd(`SPS_OFF_STATUS, 8'h30);
    rd(`SPS_OFF_CTRL1, 8'h40);
    tb_ss <= 1'b1;
    repeat (3) @(posedge clk);
    wr(`SPS_OFF_CTRL1, 8'h50);
    rd(`SPS_OFF_STATUS, 8'h20);
    $display("test pins and fault done");
    // slave byte clocked by the bench, 6 clocks per half period
    wr(`SPS_OFF_CTRL2, 8'h00);
    wr(`SPS_OFF_CTRL1, 8'h40);
    d = 8'($urandom);
    m = 8'($urandom);
    wr(`SPS_OFF_DATA, d);
    rd(`SPS_OFF_STATUS, 8'h00);
    chk("pin use", 32'(po), 32'haa);
    tb_ss <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      tb_mosi <= m[b];
      repeat (6) @(posedge clk);
      chk("slave out", 32'({miso_p.oe, miso_p.o}), 32'({1'b1, d[b]}));
      tb_sck <= 1'b1;
      repeat (6) @(posedge clk);
      tb_sck <= 1'b0;
    end
    repeat (6) @(posedge clk);
    tb_ss <= 1'b1;
    repeat (6) @(posedge clk);
    rd(`SPS_OFF_STATUS, 8'ha0);
    rd(`SPS_OFF_DATA, m);
    $display("test slave transfer done");
    // light sleep mid-byte freezes the transfer, then an abort, then deep sleep
    wr(`SPS_OFF_CTRL2, 8'h10);
    wr(`SPS_OFF_CTRL1, 8'h52);
    wr(`SPS_OFF_DATA, 8'h5a);
    repeat (200) @(posedge clk);
    light_sleep <= 1'b1;
    repeat (4) @(posedge clk);
    chk("pin use", 32'(po), 32'h0);
    light_sleep <= 1'b0;
    repeat (2) @(posedge clk);
    chk("select held", 32'({sel_p.oe, sel_p.o}), 32'h2);
    rd(`SPS_OFF_CTRL1, 8'h52);
    wr(`SPS_OFF_CTRL1, 8'h00);
    rd(`SPS_OFF_STATUS, 8'h20);
    chk("pin use", 32'(po), 32'h0);
    wr(`SPS_OFF_CTRL1, 8'h50);
    deep_sleep <= 1'b1;
    repeat (2) @(posedge clk);
    deep_sleep <= 1'b0;
    @(posedge clk);
    rd(`SPS_OFF_CTRL1, 8'h04);
    rd(`SPS_OFF_BAUD, 8'h00);
    chk("open notes", 32'(exp_q.size()), 32'h0);
    $display("test abort and sleep done");
    complete_run();
  end
endmodule
`default_nettype wire
